/* File: include/dofd_defs.svh */
`ifndef DOFD_DEFS_SVH
`define DOFD_DEFS_SVH

// ----------------------------------------------------------------------------
// Multiply pair selector codes
// ----------------------------------------------------------------------------
`define DOFD_MPAIR_W4_W5 3'h0
`define DOFD_MPAIR_W4_W6 3'h1
`define DOFD_MPAIR_W4_W7 3'h2
`define DOFD_MPAIR_W5_W6 3'h3
`define DOFD_MPAIR_W5_W7 3'h4
`define DOFD_MPAIR_W6_W7 3'h5

// ----------------------------------------------------------------------------
// Source addressing mode codes
// ----------------------------------------------------------------------------
`define DOFD_SM_DIRECT 3'h0
`define DOFD_SM_IND 3'h1
`define DOFD_SM_POSTDEC 3'h2
`define DOFD_SM_POSTINC 3'h3
`define DOFD_SM_PREDEC 3'h4
`define DOFD_SM_PREINC 3'h5
`define DOFD_SM_BASEOFS 3'h6

// ----------------------------------------------------------------------------
// Working register numbers
// ----------------------------------------------------------------------------
`define DOFD_W0 4'h0
`define DOFD_W4 4'h4
`define DOFD_W5 4'h5
`define DOFD_W6 4'h6
`define DOFD_W7 4'h7
`define DOFD_W8 4'h8
`define DOFD_W9 4'h9
`define DOFD_W10 4'ha
`define DOFD_W11 4'hb
`define DOFD_W12 4'hc

// ----------------------------------------------------------------------------
// Prefetch selector codes and post-modify steps (two's complement bytes)
// ----------------------------------------------------------------------------
`define DOFD_PF_HALF 4'h7
`define DOFD_PF_OFS 4'he
`define DOFD_PF_NONE 4'hf
`define DOFD_STEP_P6 8'h06
`define DOFD_STEP_P4 8'h04
`define DOFD_STEP_P2 8'h02
`define DOFD_STEP_0 8'h00
`define DOFD_STEP_M6 8'hfa
`define DOFD_STEP_M4 8'hfc
`define DOFD_STEP_M2 8'hfe

`endif

/* File: include/dofd_pkg.sv */
`default_nettype none

package dofd_pkg;

  // Decoded addressing form of a register operand
  typedef enum logic [2:0] {
    DOFD_AM_DIRECT,
    DOFD_AM_IND,
    DOFD_AM_POSTDEC,
    DOFD_AM_POSTINC,
    DOFD_AM_PREDEC,
    DOFD_AM_PREINC,
    DOFD_AM_BASEOFS
  } dofd_amode_e;

  // Raw operand fields from the fetch stage
  typedef struct packed {
    logic is_dsp_mul;
    logic [2:0] mul_sel;
    logic is_file_op;
    logic [2:0] src_mode;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic is_acc_src;
    logic [2:0] acc_mode;
    logic [3:0] acc_reg;
    logic [3:0] acc_base;
    logic [3:0] x_sel;
    logic [1:0] x_dst;
    logic [3:0] y_sel;
    logic [1:0] y_dst;
  } dofd_fields_s;

  // One prefetch channel request
  typedef struct packed {
    logic rd_en;
    logic [3:0] ptr;
    logic ofs_en;
    logic [3:0] ofs_reg;
    logic upd_en;
    logic [7:0] step;
    logic wb_en;
    logic [3:0] dst;
  } dofd_pf_s;

  // Decoded operand bundle for address generation and datapath
  typedef struct packed {
    logic mul_en;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    logic file_en;
    logic [3:0] file_reg;
    dofd_amode_e src_am;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic acc_en;
    dofd_amode_e acc_am;
    logic [3:0] acc_reg;
    logic [3:0] acc_base;
    dofd_pf_s x_pf;
    dofd_pf_s y_pf;
  } dofd_result_s;

  // Illegal field flags
  typedef struct packed {
    logic mul_bad;
    logic src_bad;
    logic acc_bad;
  } dofd_err_s;

endpackage : dofd_pkg

`default_nettype wire

/* File: logic/dofd_prefetch_map.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dofd_defs.svh"

// ----------------------------------------------------------------------------
// One prefetch channel: selector to pointer, modify and destination
// ----------------------------------------------------------------------------
module dofd_prefetch_map
  import dofd_pkg::*;
#(
  parameter logic [3:0] PTR_LO = `DOFD_W8,
  parameter logic [3:0] PTR_HI = `DOFD_W9
) (
  input wire logic [3:0] sel_i,
  input wire logic [1:0] dst_i,
  output dofd_pf_s pf_o
);

  logic [3:0] step_idx;

  // Low seven codes use the first pointer, next seven the second
  assign step_idx = (sel_i < `DOFD_PF_HALF) ? sel_i : (sel_i - `DOFD_PF_HALF);

  // Map selector; the none code leaves every enable low
  always_comb begin
    pf_o = '0;
    if (sel_i != `DOFD_PF_NONE) begin
      pf_o.rd_en = 1'b1;
      pf_o.wb_en = 1'b1;
      pf_o.dst = `DOFD_W4 + {2'h0, dst_i};
      if (sel_i == `DOFD_PF_OFS) begin
        pf_o.ptr = PTR_HI;
        pf_o.ofs_en = 1'b1;
        pf_o.ofs_reg = `DOFD_W12;
      end else begin
        pf_o.ptr = (sel_i < `DOFD_PF_HALF) ? PTR_LO : PTR_HI;
        pf_o.upd_en = (step_idx != 4'h3);
        case (step_idx)
          4'h0: pf_o.step = `DOFD_STEP_P6;
          4'h1: pf_o.step = `DOFD_STEP_P4;
          4'h2: pf_o.step = `DOFD_STEP_P2;
          4'h4: pf_o.step = `DOFD_STEP_M6;
          4'h5: pf_o.step = `DOFD_STEP_M4;
          4'h6: pf_o.step = `DOFD_STEP_M2;
          default: pf_o.step = `DOFD_STEP_0;
        endcase
      end
    end
  end

endmodule : dofd_prefetch_map
`default_nettype wire

/* File: logic/dofd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dofd_defs.svh"

// Behaviour
// - Multiply pairs: six distinct pairs of W4-W7
// - Register selectors reach all sixteen working registers
// - File operations always imply working register zero
// - Source: direct, indirect, pre/post modified indirect
// - Accumulator source: modified indirect, base plus offset
// - X prefetch: W8/W9 steps, W9+W12, none
// - Y prefetch: W10/W11 steps, W11+W12, none
// - X prefetch data lands in W4-W7
// - Y prefetch data lands in W4-W7
module dofd_decoder
  import dofd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic dec_valid_i,
  input wire dofd_fields_s fields_i,
  output logic dec_valid_o,
  output dofd_result_s result_o,
  output dofd_err_s err_o,
  output logic illegal_o
);

  // --------------------------------------------------------------------------
  // Combinational decode
  // --------------------------------------------------------------------------
  dofd_result_s result_next;
  dofd_err_s err_next;
  dofd_pf_s x_pf;
  dofd_pf_s y_pf;
  logic [3:0] mul_a_next;
  logic [3:0] mul_b_next;
  logic mul_ok;
  dofd_amode_e src_am_next;
  logic src_ok;
  dofd_amode_e acc_am_next;
  logic acc_ok;

  // --------------------------------------------------------------------------
  // Prefetch channels
  // --------------------------------------------------------------------------
  // One mapper per data space; only the pointer pair differs
  dofd_prefetch_map #(
    .PTR_LO(`DOFD_W8),
    .PTR_HI(`DOFD_W9)
  ) u_x_map (
    .sel_i(fields_i.x_sel),
    .dst_i(fields_i.x_dst),
    .pf_o(x_pf)
  );

  dofd_prefetch_map #(
    .PTR_LO(`DOFD_W10),
    .PTR_HI(`DOFD_W11)
  ) u_y_map (
    .sel_i(fields_i.y_sel),
    .dst_i(fields_i.y_dst),
    .pf_o(y_pf)
  );

  // --------------------------------------------------------------------------
  // Multiply pair
  // --------------------------------------------------------------------------
  // Square pairs are a different instruction class, so equal registers
  // never come out of this table
  // An illegal code still leaves a legal pair on the bus; the cleared
  // enable is what keeps the datapath from using it
  always_comb begin
    mul_ok = 1'b1;
    mul_a_next = `DOFD_W4;
    mul_b_next = `DOFD_W5;
    case (fields_i.mul_sel)
      `DOFD_MPAIR_W4_W5: begin
        mul_a_next = `DOFD_W4;
        mul_b_next = `DOFD_W5;
      end
      `DOFD_MPAIR_W4_W6: begin
        mul_a_next = `DOFD_W4;
        mul_b_next = `DOFD_W6;
      end
      `DOFD_MPAIR_W4_W7: begin
        mul_a_next = `DOFD_W4;
        mul_b_next = `DOFD_W7;
      end
      `DOFD_MPAIR_W5_W6: begin
        mul_a_next = `DOFD_W5;
        mul_b_next = `DOFD_W6;
      end
      `DOFD_MPAIR_W5_W7: begin
        mul_a_next = `DOFD_W5;
        mul_b_next = `DOFD_W7;
      end
      `DOFD_MPAIR_W6_W7: begin
        mul_a_next = `DOFD_W6;
        mul_b_next = `DOFD_W7;
      end
      default: begin
        mul_ok = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // General source addressing
  // --------------------------------------------------------------------------
  always_comb begin
    src_ok = 1'b1;
    case (fields_i.src_mode)
      `DOFD_SM_DIRECT: src_am_next = DOFD_AM_DIRECT;
      `DOFD_SM_IND: src_am_next = DOFD_AM_IND;
      `DOFD_SM_POSTDEC: src_am_next = DOFD_AM_POSTDEC;
      `DOFD_SM_POSTINC: src_am_next = DOFD_AM_POSTINC;
      `DOFD_SM_PREDEC: src_am_next = DOFD_AM_PREDEC;
      `DOFD_SM_PREINC: src_am_next = DOFD_AM_PREINC;
      default: begin
        src_am_next = DOFD_AM_DIRECT;
        src_ok = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Accumulator source addressing
  // --------------------------------------------------------------------------
  // Plain direct and plain indirect codes are refused here; a refused code
  // still puts plain indirect on the bus, and the cleared enable stops its use
  always_comb begin
    acc_ok = 1'b1;
    case (fields_i.acc_mode)
      `DOFD_SM_POSTDEC: acc_am_next = DOFD_AM_POSTDEC;
      `DOFD_SM_POSTINC: acc_am_next = DOFD_AM_POSTINC;
      `DOFD_SM_PREDEC: acc_am_next = DOFD_AM_PREDEC;
      `DOFD_SM_PREINC: acc_am_next = DOFD_AM_PREINC;
      `DOFD_SM_BASEOFS: acc_am_next = DOFD_AM_BASEOFS;
      default: begin
        acc_am_next = DOFD_AM_IND;
        acc_ok = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Result assembly
  // --------------------------------------------------------------------------
  // A refused multiply or accumulator field drops its enable so nothing downstream acts on it; a refused source only raises src_bad
  always_comb begin
    result_next = '0;
    result_next.mul_en = fields_i.is_dsp_mul & mul_ok;
    result_next.mul_a = mul_a_next;
    result_next.mul_b = mul_b_next;
    result_next.file_en = fields_i.is_file_op;
    result_next.file_reg = `DOFD_W0;
    result_next.src_am = src_am_next;
    result_next.src_reg = fields_i.src_reg;
    result_next.dst_reg = fields_i.dst_reg;
    result_next.acc_en = fields_i.is_acc_src & acc_ok;
    result_next.acc_am = acc_am_next;
    result_next.acc_reg = fields_i.acc_reg;
    // Base register reads as zero unless the base form is chosen, so a
    // stale field never reaches the address adder
    result_next.acc_base = (acc_am_next == DOFD_AM_BASEOFS) ? fields_i.acc_base : 4'h0;
    // Prefetch only exists in the multiply class; none keeps all off
    if (fields_i.is_dsp_mul) begin
      result_next.x_pf = x_pf;
      result_next.y_pf = y_pf;
    end
  end

  // --------------------------------------------------------------------------
  // Error flags
  // --------------------------------------------------------------------------
  // Only a field that the instruction class uses can raise an error, so a
  // stray code in an unused field never flags a legal instruction
  always_comb begin
    err_next = '0;
    err_next.mul_bad = fields_i.is_dsp_mul & ~mul_ok;
    err_next.acc_bad = fields_i.is_acc_src & ~acc_ok;
    err_next.src_bad = ~fields_i.is_acc_src & ~fields_i.is_file_op & ~src_ok;
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // Valid strobe follows the request by one cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
    end else begin
      dec_valid_o <= dec_valid_i;
    end
  end

  // Result is held between requests so the datapath can sample late;
  // costs a wide enable mux but saves a capture stage downstream
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (dec_valid_i) begin
      result_o <= result_next;
    end
  end

  // Error flags are cleared to zero on cycles with no request
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      err_o <= '0;
      illegal_o <= 1'b0;
    end else if (dec_valid_i) begin
      err_o <= err_next;
      illegal_o <= |err_next;
    end else begin
      err_o <= '0;
      illegal_o <= 1'b0;
    end
  end

endmodule : dofd_decoder
`default_nettype wire

/* File: verification/dofd_decoder_checker.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Port checker for the operand decoder
// ----------------------------------------------------------------------------
module dofd_decoder_checker
  import dofd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic dec_valid_i,
  input wire dofd_fields_s fields_i,
  input wire logic dec_valid_o,
  input wire dofd_result_s result_o,
  input wire dofd_err_s err_o,
  input wire logic illegal_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Taken request, and a taken request of the multiply class
  sequence s_take;
    dec_valid_i;
  endsequence
  sequence s_mul;
    dec_valid_i && fields_i.is_dsp_mul;
  endsequence

  property p_answer;
    s_take |=> dec_valid_o && (illegal_o == |err_o);
  endproperty
  property p_idle;
    !dec_valid_i |=> !dec_valid_o && !illegal_o && $stable(result_o);
  endproperty
  property p_pair;
    s_mul ##0 (fields_i.mul_sel < 3'h6) |=> result_o.mul_en && result_o.mul_a >= 4'h4
      && result_o.mul_b > result_o.mul_a && result_o.mul_b <= 4'h7;
  endproperty
  property p_mulbad;
    s_mul ##0 (fields_i.mul_sel > 3'h5) |=> err_o.mul_bad && !result_o.mul_en;
  endproperty
  property p_file;
    s_take ##0 fields_i.is_file_op |=> result_o.file_en && result_o.file_reg == 4'h0;
  endproperty
  // Plain direct form must pass the register number untouched
  property p_src;
    s_take ##0 (!fields_i.is_acc_src && !fields_i.is_file_op && fields_i.src_mode == 3'h0)
      |=> result_o.src_am == DOFD_AM_DIRECT && result_o.src_reg == $past(fields_i.src_reg);
  endproperty
  property p_accdir;
    s_take ##0 (fields_i.is_acc_src && fields_i.acc_mode == 3'h0)
      |=> err_o.acc_bad && !result_o.acc_en;
  endproperty
  property p_xofs;
    s_mul ##0 (fields_i.x_sel == 4'he) |=> result_o.x_pf.ptr == 4'h9
      && result_o.x_pf.ofs_reg == 4'hc && !result_o.x_pf.upd_en;
  endproperty
  property p_ynone;
    s_mul ##0 (fields_i.y_sel == 4'hf) |=> result_o.y_pf == '0;
  endproperty
  property p_yofs;
    s_mul ##0 (fields_i.y_sel == 4'he) |=> result_o.y_pf.ptr == 4'hb
      && result_o.y_pf.ofs_reg == 4'hc && !result_o.y_pf.upd_en;
  endproperty
  property p_xdst;
    s_mul ##0 (fields_i.x_sel != 4'hf) |=> result_o.x_pf.wb_en
      && result_o.x_pf.dst == 4'h4 + {2'h0, $past(fields_i.x_dst)};
  endproperty

  a_answer: assert property (p_answer) else $error("no answer after request");
  a_idle: assert property (p_idle) else $error("output moved without request");
  a_pair: assert property (p_pair) else $error("bad multiply pair");
  a_mulbad: assert property (p_mulbad) else $error("illegal pair accepted");
  a_file: assert property (p_file) else $error("file op reg not zero");
  a_src: assert property (p_src) else $error("direct source wrong");
  a_accdir: assert property (p_accdir) else $error("acc direct accepted");
  a_xofs: assert property (p_xofs) else $error("x offset form wrong");
  a_ynone: assert property (p_ynone) else $error("y none not idle");
  a_yofs: assert property (p_yofs) else $error("y offset form wrong");
  a_xdst: assert property (p_xdst) else $error("x destination wrong");
endmodule : dofd_decoder_checker

bind dofd_decoder dofd_decoder_checker u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .dec_valid_i(dec_valid_i), .fields_i(fields_i),
  .dec_valid_o(dec_valid_o), .result_o(result_o), .err_o(err_o), .illegal_o(illegal_o)
);

`default_nettype wire

/* File: verification/test_dsp_operand_field_decoder.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Self-checking bench: random requests, queued expectations
// ----------------------------------------------------------------------------
module test_dsp_operand_field_decoder;
  import dofd_pkg::*;

  typedef struct packed {
    logic src_use;
    dofd_result_s r;
    dofd_err_s e;
  } dofd_exp_s;

  logic mclk_i;
  logic rst_i;
  logic dec_valid_i;
  dofd_fields_s fields_i;
  logic dec_valid_o;
  dofd_result_s result_o;
  dofd_err_s err_o;
  logic illegal_o;
  dofd_exp_s exp_q[$];
  dofd_exp_s mx;
  logic [15:0] seed;
  int fail_count = 0;
  int n_tests = 0;

  dofd_decoder uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .dec_valid_i(dec_valid_i), .fields_i(fields_i),
    .dec_valid_o(dec_valid_o), .result_o(result_o), .err_o(err_o), .illegal_o(illegal_o)
  );

  // 100 ns clock
  always #50 mclk_i = ~mclk_i;

  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // Prefetch channel expectation; selector 14 uses the second pointer
  function automatic dofd_pf_s pf_exp(logic [3:0] s, logic [1:0] d, logic [3:0] p0);
    dofd_pf_s p;
    int k;
    p = '0;
    k = (s > 4'h6) ? int'(s) - 7 : int'(s);
    if (s != 4'hf) begin
      p.rd_en = 1'b1;
      p.wb_en = 1'b1;
      p.dst = {2'h1, d};
      p.ptr = (s > 4'h6) ? p0 + 4'h1 : p0;
    end
    if (s == 4'he) begin
      p.ofs_en = 1'b1;
      p.ofs_reg = 4'hc;
    end else if (s != 4'hf) begin
      p.step = 8'(k < 3 ? 6 - 2 * k : (k == 3 ? 0 : 2 * k - 14));
      p.upd_en = (k != 3);
    end
    return p;
  endfunction : pf_exp

  function automatic dofd_exp_s exp_of(dofd_fields_s f);
    dofd_exp_s x;
    x = '0;
    x.src_use = !f.is_acc_src && !f.is_file_op;
    x.r.dst_reg = f.dst_reg;
    x.r.file_en = f.is_file_op;
    x.r.src_am = dofd_amode_e'(f.src_mode);
    x.r.src_reg = f.src_reg;
    x.e.src_bad = x.src_use && f.src_mode > 3'h5;
    x.e.acc_bad = f.is_acc_src && (f.acc_mode < 3'h2 || f.acc_mode == 3'h7);
    x.r.acc_en = f.is_acc_src && !x.e.acc_bad;
    x.r.acc_am = dofd_amode_e'(f.acc_mode);
    x.r.acc_reg = f.acc_reg;
    x.r.acc_base = (f.acc_mode == 3'h6) ? f.acc_base : 4'h0;
    if (f.is_dsp_mul) begin
      x.e.mul_bad = f.mul_sel > 3'h5;
      x.r.mul_en = !x.e.mul_bad;
      x.r.mul_a = 4'(f.mul_sel < 3 ? 4 : (f.mul_sel < 5 ? 5 : 6));
      x.r.mul_b = 4'(f.mul_sel < 3 ? 5 + f.mul_sel : (f.mul_sel < 5 ? 3 + f.mul_sel : 7));
      x.r.x_pf = pf_exp(f.x_sel, f.x_dst, 4'h8);
      x.r.y_pf = pf_exp(f.y_sel, f.y_dst, 4'ha);
    end
    return x;
  endfunction : exp_of

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Random requests, about three in four cycles, often back to back
  task automatic run(input int n);
    logic [15:0] a;
    logic [15:0] b;
    dofd_fields_s f;
    logic v;
    repeat (n) begin
      @(posedge mclk_i);
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(lfsr(seed));
      b = seed;
      seed = lfsr(seed);
      f = dofd_fields_s'({seed[7:0], a, b});
      v = seed[9:8] != 2'b00;
      dec_valid_i <= v;
      fields_i <= f;
      if (v) exp_q.push_back(exp_of(f));
    end
    @(posedge mclk_i);
    dec_valid_i <= 1'b0;
  endtask : run

  // Result watcher; compares on the cycle the answer stands
  always @(negedge mclk_i) begin
    if (dec_valid_o === 1'b1 && exp_q.size() == 0) chk("dec_valid_o", 0, 1);
    else if (dec_valid_o === 1'b1) begin
      mx = exp_q.pop_front();
      chk("mul_en", mx.r.mul_en, result_o.mul_en);
      if (mx.r.mul_en) begin
        chk("mul_pair", {mx.r.mul_a, mx.r.mul_b},
            {result_o.mul_a, result_o.mul_b});
      end
      chk("file", {mx.r.file_en, mx.r.file_reg}, {result_o.file_en, result_o.file_reg});
      chk("dst_reg", mx.r.dst_reg, result_o.dst_reg);
      if (mx.src_use && !mx.e.src_bad) begin
        chk("src", {mx.r.src_am, mx.r.src_reg},
            {result_o.src_am, result_o.src_reg});
      end
      chk("acc_en", mx.r.acc_en, result_o.acc_en);
      if (mx.r.acc_en) begin
        chk("acc", {mx.r.acc_am, mx.r.acc_reg, mx.r.acc_base},
            {result_o.acc_am, result_o.acc_reg, result_o.acc_base});
      end
      chk("x_pf", mx.r.x_pf, result_o.x_pf);
      chk("y_pf", mx.r.y_pf, result_o.y_pf);
      chk("err", {mx.e, |mx.e}, {err_o, illegal_o});
    end
  end

  // Watchdog: far beyond the two runs of 800 cycles
  initial begin
    #(100 * 4000);
    fail_count++;
    results();
  end

  initial begin
    mclk_i = 1'b0;
    rst_i = 1'b1;
    dec_valid_i = 1'b0;
    fields_i = '0;
    seed = 16'h9a2d;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    run(800);
    // Mid-run reset must clear every output
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk("reset", '0, {dec_valid_o, illegal_o, err_o, result_o});
    run(800);
    repeat (3) @(posedge mclk_i);
    chk("pending", 0, exp_q.size());
    results();
  end
endmodule : test_dsp_operand_field_decoder

`default_nettype wire
